//--- hw/strobe_pin_pkg.sv
// Shared constants for the memory data-side pin function block
package strobe_pin_pkg;
    localparam int unsigned ORG_X4 = 4;
    localparam int unsigned ORG_X8 = 8;
    localparam int unsigned ORG_X16 = 16;
    localparam int unsigned MAX_DQ = 16;
    localparam int unsigned SINGLE_ENDED_STROBE_BIT = 10;
    localparam int unsigned REDUNDANT_STROBE_BIT = 11;
    localparam int unsigned EMR_WIDTH = 14;
    localparam logic [13:0] EMR_RESET = 14'h0000;
    localparam logic [3:0] LINK_DIV = 4'h4;
    localparam int unsigned BEATS_PER_BURST = 4;
    localparam logic [2:0] LAST_BEAT = 3'h3;
endpackage

//--- hw/strobe_pin_if.sv
// Pin-level carrier between controller and memory data side
`timescale 1ns/1ps
`default_nettype none
interface strobe_pin_if;
    logic link_clk;
    logic emr_load;
    logic [13:0] emr_value;
    logic rd_cmd;
    logic wr_cmd;
    logic [15:0] dq_ctl_o, dq_ctl_oe, dq_mem_o, dq_mem_oe;
    logic [1:0] dqs_ctl_o, dqs_ctl_oe, dqs_mem_o, dqs_mem_oe;
    logic [1:0] dqs_n_ctl_o, dqs_n_ctl_oe, dqs_n_mem_o, dqs_n_mem_oe;
    logic [1:0] write_mask_ctl_o, write_mask_ctl_oe;
    logic redundant_read_strobe_o, redundant_read_strobe_oe;
    logic redundant_read_strobe_inv_o, redundant_read_strobe_inv_oe;
    // Resolved pin levels
    logic [15:0] dq;
    logic [1:0] dqs, dqs_n, write_mask;
    assign dq = dq_mem_oe & dq_mem_o | dq_ctl_oe & dq_ctl_o;
    assign dqs = dqs_mem_oe & dqs_mem_o | dqs_ctl_oe & dqs_ctl_o;
    assign dqs_n = dqs_n_mem_oe & dqs_n_mem_o | dqs_n_ctl_oe & dqs_n_ctl_o;
    // Shared ball: mask from controller or redundant strobe from memory
    assign write_mask = {write_mask_ctl_o[1] & write_mask_ctl_oe[1],
        write_mask_ctl_oe[0] ? write_mask_ctl_o[0] : redundant_read_strobe_o & redundant_read_strobe_oe};
    modport ctl (output link_clk, emr_load, emr_value, rd_cmd, wr_cmd, dq_ctl_o, dq_ctl_oe, dqs_ctl_o,
        dqs_ctl_oe, dqs_n_ctl_o, dqs_n_ctl_oe, write_mask_ctl_o, write_mask_ctl_oe,
        input dq, dqs, dqs_n);
    modport mem (input link_clk, emr_load, emr_value, rd_cmd, wr_cmd, dq, dqs, dqs_n, write_mask,
        output dq_mem_o, dq_mem_oe, dqs_mem_o, dqs_mem_oe, dqs_n_mem_o, dqs_n_mem_oe,
        redundant_read_strobe_o, redundant_read_strobe_oe,
        redundant_read_strobe_inv_o, redundant_read_strobe_inv_oe);
endinterface
`default_nettype wire

//--- hw/strobe_mem_end.sv
// Memory end: data, strobe and mask ball functions
//
`timescale 1ns/1ps
`default_nettype none
module strobe_mem_end #(
    parameter int unsigned ORG = strobe_pin_pkg::ORG_X8
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    strobe_pin_if.mem pins,
    input wire logic [15:0] i_rd_data,
    output logic [15:0] o_wr_data,
    output logic o_wr_valid,
    output logic [13:0] o_emr
);
    localparam int unsigned W = ORG;
    localparam int unsigned NLANE = (ORG == strobe_pin_pkg::ORG_X16) ? 2 : 1;
    localparam logic [15:0] DQ_MASK = 16'((32'h1 << W) - 32'h1);

    logic [2:0] clk_sync_ff, rd_sync_ff, wr_sync_ff, ld_sync_ff;
    logic [13:0] emr_ff;
    logic [2:0] beat_ff;
    logic rd_active_ff, wr_active_ff, strobe_ff;
    logic [15:0] dq_o_ff, dq_oe_ff, wr_data_ff;
    logic [1:0] dqs_o_ff, dqs_oe_ff, dqs_n_o_ff, dqs_n_oe_ff;
    logic rr_o_ff, rr_oe_ff, rr_n_o_ff, rr_n_oe_ff, wr_valid_ff;
    logic rd_drive_ff, served_ff;
    logic [15:0] rd_beat_ff;
    logic link_rise, link_fall, link_edge, diff_en, rr_en;
    logic [1:0] mask_now;

    // Link clock, command and mode load pins are asynchronous to the system clock: two flops before use
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            clk_sync_ff <= 3'h0;
            rd_sync_ff <= 3'h0;
            wr_sync_ff <= 3'h0;
            ld_sync_ff <= 3'h0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[1:0], pins.link_clk};
            rd_sync_ff <= {rd_sync_ff[1:0], pins.rd_cmd};
            wr_sync_ff <= {wr_sync_ff[1:0], pins.wr_cmd};
            ld_sync_ff <= {ld_sync_ff[1:0], pins.emr_load};
        end
    end
    assign link_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
    assign link_fall = ~clk_sync_ff[1] & clk_sync_ff[2];
    assign link_edge = link_rise | link_fall;
    assign diff_en = ~emr_ff[strobe_pin_pkg::SINGLE_ENDED_STROBE_BIT];
    assign rr_en = (ORG == strobe_pin_pkg::ORG_X8) && emr_ff[strobe_pin_pkg::REDUNDANT_STROBE_BIT];

    // Mode load is held stable by the controller across several link edges
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            emr_ff <= strobe_pin_pkg::EMR_RESET;
        end else if (ld_sync_ff[1] && link_rise) begin
            emr_ff <= pins.emr_value;
        end
    end

    // Burst framing: a burst starts on a rising link edge, one beat per edge
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rd_active_ff <= 1'b0;
            wr_active_ff <= 1'b0;
            beat_ff <= 3'h0;
        end else if (rd_active_ff || wr_active_ff) begin
            if (link_edge) begin
                beat_ff <= beat_ff + 3'h1;
                if (beat_ff == strobe_pin_pkg::LAST_BEAT) begin
                    rd_active_ff <= 1'b0;
                    wr_active_ff <= 1'b0;
                end
            end
        end else if (link_rise && !served_ff) begin
            beat_ff <= 3'h0;
            rd_active_ff <= rd_sync_ff[1];
            wr_active_ff <= wr_sync_ff[1] & ~rd_sync_ff[1];
        end
    end

    // Commands are levels held much longer than a burst: serve each one once
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            served_ff <= 1'b0;
        end else if (!rd_active_ff && !wr_active_ff && link_rise && !served_ff) begin
            served_ff <= rd_sync_ff[1] | wr_sync_ff[1];
        end else if (!rd_sync_ff[1] && !wr_sync_ff[1]) begin
            served_ff <= 1'b0;
        end
    end

    // Read side: strobe toggles with each new data beat, edge aligned
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            strobe_ff <= 1'b0;
            rd_beat_ff <= 16'h0000;
        end else begin
            if (rd_active_ff && link_edge) begin
                strobe_ff <= ~beat_ff[0];
                rd_beat_ff <= i_rd_data & DQ_MASK;
            end else if (!rd_active_ff) begin
                strobe_ff <= 1'b0;
            end
        end
    end

    // Drive window opens with the first loaded beat and closes one half
    // period after the last, so no stale word ever reaches the bus
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rd_drive_ff <= 1'b0;
        end else if (rd_active_ff && link_edge) begin
            rd_drive_ff <= 1'b1;
        end else if (!rd_active_ff && link_edge) begin
            rd_drive_ff <= 1'b0;
        end
    end

    // Data leaves through one more flop, matching the strobe lane flops
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            dq_o_ff <= 16'h0000;
            dq_oe_ff <= 16'h0000;
        end else begin
            dq_o_ff <= rd_beat_ff;
            dq_oe_ff <= rd_drive_ff ? DQ_MASK : 16'h0000;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    dqs_o_ff[g] <= 1'b0;
                    dqs_oe_ff[g] <= 1'b0;
                    dqs_n_o_ff[g] <= 1'b0;
                    dqs_n_oe_ff[g] <= 1'b0;
                end else begin
                    dqs_o_ff[g] <= strobe_ff;
                    dqs_oe_ff[g] <= rd_drive_ff && (g < NLANE);
                    dqs_n_o_ff[g] <= ~strobe_ff;
                    dqs_n_oe_ff[g] <= rd_drive_ff && (g < NLANE) && diff_en;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rr_o_ff <= 1'b0;
            rr_oe_ff <= 1'b0;
            rr_n_o_ff <= 1'b0;
            rr_n_oe_ff <= 1'b0;
        end else begin
            rr_o_ff <= strobe_ff;
            rr_oe_ff <= rr_en & rd_drive_ff;
            rr_n_o_ff <= ~strobe_ff;
            rr_n_oe_ff <= rr_en & diff_en & rd_drive_ff;
        end
    end

    // Write side: the mask ball is read as mask only while the redundant strobe is off
    assign mask_now = {pins.write_mask[1], pins.write_mask[0] & ~rr_en};
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wr_data_ff <= 16'h0000;
            wr_valid_ff <= 1'b0;
        end else begin
            wr_valid_ff <= 1'b0;
            if (wr_active_ff && link_edge) begin
                if (ORG == strobe_pin_pkg::ORG_X16) begin
                    // Each mask keeps its own byte; a fully masked beat is dropped
                    wr_data_ff <= {mask_now[1] ? 8'h00 : pins.dq[15:8], mask_now[0] ? 8'h00 : pins.dq[7:0]};
                    wr_valid_ff <= ~(mask_now[1] & mask_now[0]);
                end else begin
                    wr_data_ff <= pins.dq & DQ_MASK;
                    wr_valid_ff <= ~mask_now[0];
                end
            end
        end
    end

    assign pins.dq_mem_o = dq_o_ff;
    assign pins.dq_mem_oe = dq_oe_ff;
    assign pins.dqs_mem_o = dqs_o_ff;
    assign pins.dqs_mem_oe = dqs_oe_ff;
    assign pins.dqs_n_mem_o = dqs_n_o_ff;
    assign pins.dqs_n_mem_oe = dqs_n_oe_ff;
    assign pins.redundant_read_strobe_o = rr_o_ff;
    assign pins.redundant_read_strobe_oe = rr_oe_ff;
    assign pins.redundant_read_strobe_inv_o = rr_n_o_ff;
    assign pins.redundant_read_strobe_inv_oe = rr_n_oe_ff;
    assign o_wr_data = wr_data_ff;
    assign o_wr_valid = wr_valid_ff;
    assign o_emr = emr_ff;
endmodule // strobe_mem_end
`default_nettype wire

//--- hw/strobe_ctl_end.sv
// Controller end: drives link clock, commands, write data, strobes and mask
`timescale 1ns/1ps
`default_nettype none
module strobe_ctl_end #(
    parameter int unsigned ORG = strobe_pin_pkg::ORG_X8
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    strobe_pin_if.ctl pins,
    input wire logic i_emr_load,
    input wire logic [13:0] i_emr_value,
    input wire logic i_rd_req,
    input wire logic i_wr_req,
    input wire logic [15:0] i_wr_data,
    input wire logic [1:0] i_wr_mask,
    output logic o_busy
);
    localparam int unsigned W = ORG;
    localparam logic [15:0] DQ_MASK = 16'((32'h1 << W) - 32'h1);
    typedef enum logic [1:0] {IDLE, LOAD, READ, WRITE} ctl_state_e;

    ctl_state_e state_ff;
    logic [3:0] div_ff;
    logic lclk_ff, half_tick;
    logic [3:0] edges_ff;
    logic [13:0] emr_ff;
    logic [15:0] dq_ff, dq_oe_ff;
    logic [1:0] dqs_ff, dqs_oe_ff, dqs_n_oe_ff, mask_ff, mask_oe_ff;
    logic rd_ff, wr_ff, ld_ff, busy_ff;

    // Link clock is divided down from the system clock
    assign half_tick = (div_ff == strobe_pin_pkg::LINK_DIV - 4'h1);
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            div_ff <= 4'h0;
            lclk_ff <= 1'b0;
        end else begin
            div_ff <= half_tick ? 4'h0 : div_ff + 4'h1;
            if (half_tick) begin
                lclk_ff <= ~lclk_ff;
            end
        end
    end

    // Command held for several link edges so the memory's synchronisers catch it
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= IDLE;
            edges_ff <= 4'h0;
            emr_ff <= strobe_pin_pkg::EMR_RESET;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            ld_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            case (state_ff)
                IDLE: begin
                    edges_ff <= 4'h0;
                    if (half_tick && lclk_ff) begin
                        if (i_emr_load) begin
                            state_ff <= LOAD;
                            emr_ff <= i_emr_value;
                            ld_ff <= 1'b1;
                            busy_ff <= 1'b1;
                        end else if (i_rd_req) begin
                            state_ff <= READ;
                            rd_ff <= 1'b1;
                            busy_ff <= 1'b1;
                        end else if (i_wr_req) begin
                            state_ff <= WRITE;
                            wr_ff <= 1'b1;
                            busy_ff <= 1'b1;
                        end
                    end
                end
                LOAD, READ, WRITE: begin
                    if (half_tick) begin
                        edges_ff <= edges_ff + 4'h1;
                        if (edges_ff == 4'hb) begin
                            state_ff <= IDLE;
                            rd_ff <= 1'b0;
                            wr_ff <= 1'b0;
                            ld_ff <= 1'b0;
                            busy_ff <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_ff <= IDLE;
                end
            endcase
        end
    end

    // Write data changes at link edges; strobe toggles mid-beat for centre alignment
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            dq_ff <= 16'h0000;
            dq_oe_ff <= 16'h0000;
            dqs_ff <= 2'h0;
            dqs_oe_ff <= 2'h0;
            dqs_n_oe_ff <= 2'h0;
            mask_ff <= 2'h0;
            mask_oe_ff <= 2'h0;
        end else begin
            dq_oe_ff <= (state_ff == WRITE) ? DQ_MASK : 16'h0000;
            dqs_oe_ff <= (state_ff == WRITE) ? 2'h3 : 2'h0;
            dqs_n_oe_ff <= (state_ff == WRITE && !emr_ff[strobe_pin_pkg::SINGLE_ENDED_STROBE_BIT]) ? 2'h3 : 2'h0;
            mask_oe_ff <= (state_ff == WRITE) ? 2'h3 : 2'h0;
            if (half_tick) begin
                dq_ff <= i_wr_data & DQ_MASK;
                mask_ff <= i_wr_mask;
            end
            if (div_ff == strobe_pin_pkg::LINK_DIV / 2 - 1) begin
                dqs_ff <= {2{lclk_ff}};
            end
        end
    end

    assign pins.link_clk = lclk_ff;
    assign pins.emr_load = ld_ff;
    assign pins.emr_value = emr_ff;
    assign pins.rd_cmd = rd_ff;
    assign pins.wr_cmd = wr_ff;
    assign pins.dq_ctl_o = dq_ff;
    assign pins.dq_ctl_oe = dq_oe_ff;
    assign pins.dqs_ctl_o = dqs_ff;
    assign pins.dqs_ctl_oe = dqs_oe_ff;
    assign pins.dqs_n_ctl_o = ~dqs_ff;
    assign pins.dqs_n_ctl_oe = dqs_n_oe_ff;
    assign pins.write_mask_ctl_o = mask_ff;
    assign pins.write_mask_ctl_oe = mask_oe_ff;
    assign o_busy = busy_ff;
endmodule // strobe_ctl_end
`default_nettype wire

//--- sim/strobe_pin_assertions.sv
// Concurrent checks on the pins between the controller end and the memory end
`timescale 1ns/1ps
`default_nettype none
module strobe_pin_assertions (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic emr_load,
    input wire logic [13:0] emr_value,
    input wire logic rd_cmd,
    input wire logic wr_cmd,
    input wire logic [15:0] dq_ctl_o,
    input wire logic [15:0] dq_ctl_oe,
    input wire logic [15:0] dq_mem_o,
    input wire logic [15:0] dq_mem_oe,
    input wire logic [1:0] dqs_ctl_o,
    input wire logic [1:0] dqs_ctl_oe,
    input wire logic [1:0] dqs_mem_o,
    input wire logic [1:0] dqs_mem_oe,
    input wire logic [1:0] dqs_n_ctl_oe,
    input wire logic [1:0] dqs_n_mem_o,
    input wire logic [1:0] dqs_n_mem_oe,
    input wire logic redundant_read_strobe_o,
    input wire logic redundant_read_strobe_oe,
    input wire logic redundant_read_strobe_inv_o,
    input wire logic redundant_read_strobe_inv_oe
);
    // Last mode word put on the pins; the memory end lags it, so checks skip load time
    logic [13:0] emr_seen_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            emr_seen_ff <= strobe_pin_pkg::EMR_RESET;
        end else if (emr_load) begin
            emr_seen_ff <= emr_value;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    sequence s_read_start; $rose(rd_cmd); endsequence
    sequence s_mem_burst; dqs_mem_oe[0] && dq_mem_oe[0]; endsequence
    sequence s_write_start; $rose(wr_cmd); endsequence
    sequence s_ctl_burst; dqs_ctl_oe[0] && dq_ctl_oe[0]; endsequence
    a_one_driver: assert property (!(|(dq_mem_oe & dq_ctl_oe)) && !(|(dqs_mem_oe & dqs_ctl_oe)))
        else $error("data or strobe driven by both ends");
    a_read_answer: assert property (s_read_start |-> ##[1:40] s_mem_burst)
        else $error("memory did not drive read burst");
    a_write_drive: assert property (s_write_start |-> ##[0:8] s_ctl_burst)
        else $error("controller did not drive write burst");
    a_read_edge_aligned: assert property (dq_mem_oe[0] && $past(dq_mem_oe[0]) && $changed(dq_mem_o[7:0])
        |-> $changed(dqs_mem_o[0]))
        else $error("read data moved without strobe edge");
    a_write_centred: assert property (dqs_ctl_oe[0] && $past(dqs_ctl_oe[0]) && $changed(dqs_ctl_o[0])
        |-> $stable(dq_ctl_o[7:0]))
        else $error("write data moved at strobe edge");
    a_diff_inverse: assert property (dqs_n_mem_oe[0] |-> dqs_mem_oe[0] && dqs_n_mem_o[0] == ~dqs_mem_o[0])
        else $error("inverted strobe not complement");
    a_single_ended: assert property (emr_seen_ff[10] && !emr_load |-> dqs_n_mem_oe == 2'b00 && dqs_n_ctl_oe == 2'b00)
        else $error("inverted strobe driven in single ended mode");
    a_rrs_not_write: assert property (wr_cmd |-> !redundant_read_strobe_oe)
        else $error("redundant strobe driven during write");
    a_rrs_off_idle: assert property (!emr_seen_ff[11] && !emr_load |-> !redundant_read_strobe_oe)
        else $error("redundant strobe driven while disabled");
    a_rrs_inv_gate: assert property (redundant_read_strobe_inv_oe |-> redundant_read_strobe_oe
        && !emr_seen_ff[10] && redundant_read_strobe_inv_o == ~redundant_read_strobe_o)
        else $error("inverted redundant strobe badly gated");
    a_rrs_tracks: assert property (redundant_read_strobe_oe |-> dqs_mem_oe[0]
        && redundant_read_strobe_o == dqs_mem_o[0])
        else $error("redundant strobe differs from read strobe");
endmodule // strobe_pin_assertions
`default_nettype wire

//--- sim/tb_sdram_strobe_data_pin_config.sv
// Testbench joining both ends of the memory data-side pins
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_strobe_data_pin_config;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic emr_load_req = 1'b0;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [1:0] ph = 2'h0;
    logic [13:0] emr_val = 14'h0000;
    logic [1:0] wr_mask = 2'h0;
    logic [15:0] rd_data = 16'h0000;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_base = 16'h005a;
    logic [15:0] wr_base = 16'h003c;
    logic [15:0] wr_out;
    logic [13:0] emr_out;
    logic wr_valid;
    logic busy;
    int mismatches = 0;
    int num_checks = 0;
    int n_valid = 0;
    int n_rrs = 0;
    int n_inv = 0;
    int n_rinv = 0;
    strobe_pin_if strobe_pin_if_inst ();
    strobe_mem_end #(.ORG(strobe_pin_pkg::ORG_X8)) strobe_mem_end_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .pins(strobe_pin_if_inst), .i_rd_data(rd_data), .o_wr_data(wr_out), .o_wr_valid(wr_valid), .o_emr(emr_out));
    strobe_ctl_end #(.ORG(strobe_pin_pkg::ORG_X8)) strobe_ctl_end_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .pins(strobe_pin_if_inst), .i_emr_load(emr_load_req), .i_emr_value(emr_val), .i_rd_req(rd_req),
        .i_wr_req(wr_req), .i_wr_data(wr_data), .i_wr_mask(wr_mask), .o_busy(busy));
    strobe_pin_assertions strobe_pin_assertions_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .emr_load(strobe_pin_if_inst.emr_load), .emr_value(strobe_pin_if_inst.emr_value),
        .rd_cmd(strobe_pin_if_inst.rd_cmd), .wr_cmd(strobe_pin_if_inst.wr_cmd),
        .dq_ctl_o(strobe_pin_if_inst.dq_ctl_o), .dq_ctl_oe(strobe_pin_if_inst.dq_ctl_oe),
        .dq_mem_o(strobe_pin_if_inst.dq_mem_o), .dq_mem_oe(strobe_pin_if_inst.dq_mem_oe),
        .dqs_ctl_o(strobe_pin_if_inst.dqs_ctl_o), .dqs_ctl_oe(strobe_pin_if_inst.dqs_ctl_oe),
        .dqs_mem_o(strobe_pin_if_inst.dqs_mem_o), .dqs_mem_oe(strobe_pin_if_inst.dqs_mem_oe),
        .dqs_n_ctl_oe(strobe_pin_if_inst.dqs_n_ctl_oe), .dqs_n_mem_o(strobe_pin_if_inst.dqs_n_mem_o),
        .dqs_n_mem_oe(strobe_pin_if_inst.dqs_n_mem_oe),
        .redundant_read_strobe_o(strobe_pin_if_inst.redundant_read_strobe_o),
        .redundant_read_strobe_oe(strobe_pin_if_inst.redundant_read_strobe_oe),
        .redundant_read_strobe_inv_o(strobe_pin_if_inst.redundant_read_strobe_inv_o),
        .redundant_read_strobe_inv_oe(strobe_pin_if_inst.redundant_read_strobe_inv_oe));
    initial begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    task automatic check(input string what, input logic [15:0] expv, input logic [15:0] got);
        num_checks++;
        if (got !== expv) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, expv, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Data flips every two cycles so beats four cycles apart carry the same word
    always @(posedge i_clk_sys) begin
        ph <= ph + 2'h1;
        rd_data <= ph[1] ? ~rd_base : rd_base;
        wr_data <= ph[1] ? ~wr_base : wr_base;
    end
    // Pins are looked at mid-cycle, where they are settled
    always @(negedge i_clk_sys) begin
        if (wr_valid === 1'b1) begin
            n_valid++;
            check("write beat", (wr_out[7:0] === ~wr_base[7:0]) ? {8'h00, ~wr_base[7:0]} : wr_base, {8'h00, wr_out[7:0]});
        end
        if (strobe_pin_if_inst.dq_mem_oe[0] === 1'b1) begin
            check("read lanes", 16'h00ff, strobe_pin_if_inst.dq_mem_oe);
            check("read beat", (strobe_pin_if_inst.dq[7:0] === ~rd_base[7:0]) ? {8'h00, ~rd_base[7:0]} : rd_base,
                {8'h00, strobe_pin_if_inst.dq[7:0]});
        end
        if (strobe_pin_if_inst.redundant_read_strobe_oe === 1'b1) begin
            n_rrs++;
            check("shared ball", {15'h0000, strobe_pin_if_inst.dqs[0]}, {15'h0000, strobe_pin_if_inst.write_mask[0]});
        end
        if (strobe_pin_if_inst.dqs_n_mem_oe[0] === 1'b1) begin
            n_inv++;
            check("inverted strobe", {15'h0000, ~strobe_pin_if_inst.dqs[0]}, {15'h0000, strobe_pin_if_inst.dqs_n[0]});
        end
        if (strobe_pin_if_inst.redundant_read_strobe_inv_oe === 1'b1) begin
            n_rinv++;
        end
    end
    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        while (busy !== lvl && k < 300) begin
            @(negedge i_clk_sys);
            k++;
        end
        if (k >= 300) begin
            check("busy wait", {15'h0000, lvl}, {15'h0000, busy});
            report_and_stop();
        end
    endtask
    // One controller request: held until taken, then released and left to finish
    task automatic op(input logic l, input logic r, input logic w);
        @(posedge i_clk_sys);
        emr_load_req <= l;
        rd_req <= r;
        wr_req <= w;
        wait_busy(1'b1);
        @(posedge i_clk_sys);
        emr_load_req <= 1'b0;
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        wait_busy(1'b0);
        repeat (24) @(posedge i_clk_sys);
    endtask
    task automatic run_case(input logic [13:0] extended_mode_reg, input logic [1:0] mask, input logic [7:0] base, input int kept,
        input logic exp_rrs, input logic exp_inv);
        @(posedge i_clk_sys);
        emr_val <= extended_mode_reg;
        wr_mask <= mask;
        rd_base <= {8'h00, base};
        wr_base <= {8'h00, ~base};
        op(1'b1, 1'b0, 1'b0);
        check("mode copy", {2'b00, extended_mode_reg}, {2'b00, emr_out});
        n_rrs = 0;
        n_inv = 0;
        n_rinv = 0;
        op(1'b0, 1'b1, 1'b0);
        check("redundant strobe", {15'h0000, exp_rrs}, {15'h0000, n_rrs > 0});
        check("inverted strobe use", {15'h0000, exp_inv}, {15'h0000, n_inv > 0});
        check("inverted redundant", {15'h0000, exp_rrs & exp_inv}, {15'h0000, n_rinv > 0});
        n_valid = 0;
        op(1'b0, 1'b0, 1'b1);
        check("kept beats", 16'(kept), 16'(n_valid));
        $display("test done mode %h mask %b", extended_mode_reg, mask);
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(negedge i_clk_sys);
        check("reset mode", 16'h0000, {2'b00, emr_out});
        check("reset busy", 16'h0000, {15'h0000, busy});
        run_case(14'h0000, 2'b00, 8'ha5, strobe_pin_pkg::BEATS_PER_BURST, 1'b0, 1'b1);
        run_case(14'h0000, 2'b01, 8'h3c, 0, 1'b0, 1'b1);
        run_case(14'h0400, 2'b00, 8'h96, strobe_pin_pkg::BEATS_PER_BURST, 1'b0, 1'b0);
        run_case(14'h0c00, 2'b01, 8'h69, strobe_pin_pkg::BEATS_PER_BURST, 1'b1, 1'b0);
        run_case(14'h0800, 2'b01, 8'hc3, strobe_pin_pkg::BEATS_PER_BURST, 1'b1, 1'b1);
        run_case(14'h0000, 2'b01, 8'h5a, 0, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule // tb_sdram_strobe_data_pin_config
`default_nettype wire
